// File: hw/sps_sequencer.sv
// Setpoint program sequencer with program store and register port
//
// Notes on behaviour
// - Each segment carries eight event output bits
// - Events change only when a segment loads or on reset
// - Run input rising edge starts selected program
// - Hold input high freezes the running segment
// - Clear input high keeps program in reset
// - Run-or-freeze: edge starts, low level holds
// - Run-or-clear: edge starts, low level resets
// - Advance edge: end segment, apply target, next
// - Repeat count 1 to 9999, zero continuous
// - Configuration mode refuses start and resets program
// - Selected program index chooses program to run
// - Stored programs 1-10 writable in every state
// - Stored program copied to working program first
// - Working program writable only in run/hold
// - Run or call replaces the working program
// - Hold allows edits to running segment copy
// - Panel commands need configurable minimum access level
// - Segment time always readable; sums past a call abandoned
// - Time scaling by dwell, ramp, resolution units
// - Millisecond times capped at 500 hours
// - Program areas at fixed legacy base addresses
// - Shared time word holds dwell or ramp duration
`timescale 1ns/1ns
`include "sps_consts.svh"

module sps_sequencer #(
   parameter int MS_CYC = `SPS_MS_CYC
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Register port
   input  wire logic [15:0]           reg_addr,
   input  wire logic [15:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [15:0]           reg_rdata,
   // Field digital inputs and instrument mode
   input  wire sps_pkg::sps_din_t     din,
   input  wire logic                  config_mode_in,
   // Front panel commands
   input  wire sps_pkg::sps_panel_t   panel_cmd,
   input  wire logic [1:0]            panel_level,
   // Sequencer outputs
   output logic      [7:0]            event_out,
   output logic      [15:0]           program_setpoint_output,
   output sps_pkg::sps_state_t        seq_state
);

   sps_pkg::sps_seg_t   mem [0:`SPS_NPROG*`SPS_NSEG-1];
   logic [13:0]         pcyc [0:`SPS_NPROG-1];
   logic [1:0]          pdwu [0:`SPS_NPROG-1];
   logic [1:0]          prmu [0:`SPS_NPROG-1];

   sps_pkg::sps_din_t   din_s1, din_s2, din_q, din_en_reg, rise;
   logic                cfg_s1, cfg_s2, cfg_reg, cfg_mode;
   sps_pkg::sps_state_t state_reg;
   logic [4:0]          seg_reg, copy_idx_reg, scan_idx_reg;
   logic [3:0]          src_reg, sel_prog_reg;
   logic [13:0]         cycles_left_reg, tick_cnt_reg;
   logic [31:0]         seg_left_reg, scan_sum_reg, rest_sum_reg;
   logic [15:0]         sp_reg;
   logic [7:0]          ev_reg;
   sps_pkg::sps_seg_t   cur_seg_reg, ld, sm;
   logic [1:0]          access_reg, res_reg;
   logic                hold_cmd_reg, scan_busy_reg, scan_ok_reg;
   logic                ms_tick, panel_ok, start_req, reset_lvl, hold_lvl;
   logic                advance, seg_end, call_ok, ptime_ok;
   logic [15:0]         poff, coff, rd_val;
   logic [3:0]          pidx, sidx;
   logic [7:0]          pword;
   logic [2:0]          fld;
   logic                in_prog, in_ctl, prog_wr, ctl_wr, is_seg;
   logic [31:0]         prog_left, seg_ms;
   logic [31:0]         seg_sc, prg_sc;

   // Duration in given units to milliseconds, held at the cap
   function automatic logic [31:0] to_ms(input logic [15:0] t,
                                         input logic [1:0]  u);
      logic [47:0] p;
      p = 48'h0;
      case (u)
         2'h0:    p = t * `SPS_SEC_MS;
         2'h1:    p = t * `SPS_MIN_MS;
         default: p = t * `SPS_HOUR_MS;
      endcase
      to_ms = (p > {16'h0, `SPS_TIME_CAP}) ? `SPS_TIME_CAP : p[31:0];
   endfunction : to_ms

   function automatic logic [31:0] sat_add(input logic [31:0] a,
                                           input logic [31:0] b);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, b};
      sat_add = (s > {1'b0, `SPS_TIME_CAP}) ? `SPS_TIME_CAP : s[31:0];
   endfunction : sat_add

   // Scaled read of a millisecond time in the resolution units
   function automatic logic [31:0] scaled(input logic [31:0] ms,
                                          input logic [1:0]  u);
      case (u)
         2'h0:    scaled = ms / `SPS_SEC_MS;
         2'h1:    scaled = ms / `SPS_MIN_MS;
         default: scaled = ms / `SPS_HOUR_MS;
      endcase
   endfunction : scaled

   // Pin synchronisers and edge history
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         din_s1 <= '0;
         din_s2 <= '0;
         din_q  <= '0;
         cfg_s1 <= 1'b0;
         cfg_s2 <= 1'b0;
      end
      else
      begin
         din_s1 <= din;
         din_s2 <= din_s1;
         din_q  <= din_s2;
         cfg_s1 <= config_mode_in;
         cfg_s2 <= cfg_s1;
      end
   end

   // Millisecond time base
   always_ff @(posedge clk)
   begin
      if (sys_rst || tick_cnt_reg == 14'(MS_CYC - 1))
         tick_cnt_reg <= 14'h0;
      else
         tick_cnt_reg <= tick_cnt_reg + 14'h1;
   end
   assign ms_tick = (tick_cnt_reg == 14'(MS_CYC - 1));

   // Address decode
   always_comb
   begin
      poff    = reg_addr - `SPS_PROG0_BASE;
      coff    = reg_addr - `SPS_CTL_BASE;
      in_prog = (reg_addr >= `SPS_PROG0_BASE) && (poff < `SPS_PROG_SPAN);
      in_ctl  = (reg_addr >= `SPS_CTL_BASE) && (coff < `SPS_CTL_SPAN);
      pidx    = 4'(poff[10:0] / `SPS_PROG_STRIDE);
      pword   = 8'(poff[10:0] - 11'(pidx) * `SPS_PROG_STRIDE);
      is_seg  = (pword >= `SPS_SEG_FIRST);
      sidx    = 4'((pword - `SPS_SEG_FIRST) >> 3);
      fld     = 3'(pword - `SPS_SEG_FIRST);
      prog_wr = reg_wr && in_prog && ((pidx != 4'h0) ||
                (state_reg == sps_pkg::ST_RUN) ||
                (state_reg == sps_pkg::ST_HOLD));
      ctl_wr  = reg_wr && in_ctl;
   end

   // Control sources
   always_comb
   begin
      rise      = din_s2 & ~din_q;
      cfg_mode  = cfg_s2 | cfg_reg;
      panel_ok  = (panel_level >= access_reg);
      start_req = (din_en_reg.run & rise.run) |
                  (din_en_reg.run_or_freeze_input &
                   rise.run_or_freeze_input) |
                  (din_en_reg.run_or_clear_input &
                   rise.run_or_clear_input) |
                  (panel_ok & panel_cmd.run) |
                  (ctl_wr && coff[3:0] == `SPS_CTL_CMD &&
                   reg_wdata == `SPS_CMD_RUN);
      reset_lvl = (din_en_reg.clear & din_s2.clear) |
                  (din_en_reg.run_or_clear_input &
                   ~din_s2.run_or_clear_input) |
                  cfg_mode |
                  (panel_ok & panel_cmd.clear) |
                  (ctl_wr && coff[3:0] == `SPS_CTL_CMD &&
                   reg_wdata == `SPS_CMD_RESET);
      hold_lvl  = (din_en_reg.hold & din_s2.hold) |
                  (din_en_reg.run_or_freeze_input &
                   ~din_s2.run_or_freeze_input) |
                  hold_cmd_reg;
      advance   = din_en_reg.advance & rise.advance;
      seg_end   = advance || (state_reg == sps_pkg::ST_RUN &&
                  ms_tick && seg_left_reg == 32'h0);
      ld        = mem[{4'h0, seg_reg[3:0]}];
      seg_ms    = to_ms(ld.seg_time, (ld.kind == sps_pkg::SK_RAMP) ?
                        prmu[0] : pdwu[0]);
      call_ok   = (ld.target[15:4] == 12'h0) &&
                  (ld.target[3:0] > src_reg) &&
                  (ld.target[3:0] <= `SPS_LAST_PROG);
   end

   // Software settings
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sel_prog_reg <= `SPS_SEL_RST;
         access_reg   <= `SPS_ACCESS_RST;
         res_reg      <= `SPS_RES_RST;
         din_en_reg   <= `SPS_DIN_EN_RST;
         cfg_reg      <= 1'b0;
      end
      else if (ctl_wr)
      begin
         case (coff[3:0])
            `SPS_CTL_SEL:
               if (reg_wdata != 16'h0 && reg_wdata <= 16'(`SPS_LAST_PROG))
                  sel_prog_reg <= reg_wdata[3:0];
            `SPS_CTL_ACCESS:
               if (reg_wdata[1:0] != 2'h0 && reg_wdata[15:2] == 14'h0)
                  access_reg <= reg_wdata[1:0];
            `SPS_CTL_RES:
               if (reg_wdata[1:0] != 2'h3)
                  res_reg <= reg_wdata[1:0];
            `SPS_CTL_DIN_EN:
               din_en_reg <= reg_wdata[5:0];
            `SPS_CTL_CONFIG:
               cfg_reg <= reg_wdata[0];
            default:
               cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Latched hold request from panel or software
   always_ff @(posedge clk)
   begin
      if (sys_rst || reset_lvl || start_req)
         hold_cmd_reg <= 1'b0;
      else if ((panel_ok & panel_cmd.hold) || (ctl_wr &&
               coff[3:0] == `SPS_CTL_CMD && reg_wdata == `SPS_CMD_HOLD))
         hold_cmd_reg <= 1'b1;
   end

   // Sequencer
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_reg       <= sps_pkg::ST_IDLE;
         seg_reg         <= 5'h0;
         src_reg         <= 4'h0;
         copy_idx_reg    <= 5'h0;
         cycles_left_reg <= 14'h0;
         seg_left_reg    <= 32'h0;
         cur_seg_reg     <= '0;
         sp_reg          <= 16'h0;
         ev_reg          <= 8'h0;
      end
      else if (reset_lvl)
      begin
         state_reg    <= sps_pkg::ST_IDLE;
         seg_reg      <= 5'h0;
         seg_left_reg <= 32'h0;
         ev_reg       <= 8'h0;
      end
      else
      begin
         case (state_reg)
            sps_pkg::ST_IDLE, sps_pkg::ST_DONE:
               if (start_req)
               begin
                  state_reg    <= sps_pkg::ST_COPY;
                  src_reg      <= sel_prog_reg;
                  copy_idx_reg <= 5'h0;
               end
            sps_pkg::ST_COPY:
               if (!reg_wr)
               begin
                  if (copy_idx_reg[4])
                  begin
                     state_reg       <= sps_pkg::ST_LOAD;
                     seg_reg         <= 5'h0;
                     cycles_left_reg <= pcyc[src_reg];
                  end
                  else
                     copy_idx_reg <= copy_idx_reg + 5'h1;
               end
            sps_pkg::ST_LOAD:
               if (seg_reg[4] || ld.kind == sps_pkg::SK_END)
               begin
                  if (cycles_left_reg != 14'h1)
                  begin
                     if (cycles_left_reg != 14'h0)
                        cycles_left_reg <= cycles_left_reg - 14'h1;
                     seg_reg <= 5'h0;
                  end
                  else
                  begin
                     state_reg <= sps_pkg::ST_DONE;
                     if (!seg_reg[4])
                        ev_reg <= ld.events;
                  end
               end
               else if (ld.kind == sps_pkg::SK_CALL)
               begin
                  if (call_ok)
                  begin
                     src_reg      <= ld.target[3:0];
                     copy_idx_reg <= 5'h0;
                     state_reg    <= sps_pkg::ST_COPY;
                  end
                  else
                     state_reg <= sps_pkg::ST_DONE;
               end
               else
               begin
                  cur_seg_reg  <= ld;
                  ev_reg       <= ld.events;
                  seg_left_reg <= seg_ms;
                  state_reg    <= hold_lvl ? sps_pkg::ST_HOLD :
                                             sps_pkg::ST_RUN;
               end
            sps_pkg::ST_RUN, sps_pkg::ST_HOLD:
               if (seg_end)
               begin
                  sp_reg    <= cur_seg_reg.target;
                  seg_reg   <= seg_reg + 5'h1;
                  state_reg <= sps_pkg::ST_LOAD;
               end
               else
               begin
                  state_reg <= hold_lvl ? sps_pkg::ST_HOLD :
                                          sps_pkg::ST_RUN;
                  if (state_reg == sps_pkg::ST_RUN && ms_tick)
                     seg_left_reg <= seg_left_reg - 32'h1;
                  if (state_reg == sps_pkg::ST_HOLD && ctl_wr)
                  begin
                     if (coff[3:0] == `SPS_CTL_RL_TGT)
                        cur_seg_reg.target <= reg_wdata;
                     if (coff[3:0] == `SPS_CTL_RL_TIME)
                     begin
                        cur_seg_reg.seg_time <= reg_wdata;
                        seg_left_reg <= to_ms(reg_wdata,
                           (cur_seg_reg.kind == sps_pkg::SK_RAMP) ?
                           prmu[0] : pdwu[0]);
                     end
                  end
               end
            default:
               state_reg <= sps_pkg::ST_IDLE;
         endcase
      end
   end

   // Program store: stored programs and the working copy
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < `SPS_NPROG; i++)
         begin
            pcyc[i] <= `SPS_CYC_RST;
            pdwu[i] <= `SPS_UNITS_RST;
            prmu[i] <= `SPS_UNITS_RST;
         end
      end
      else if (state_reg == sps_pkg::ST_COPY && !reg_wr)
      begin
         if (copy_idx_reg[4])
         begin
            pcyc[0] <= pcyc[src_reg];
            pdwu[0] <= pdwu[src_reg];
            prmu[0] <= prmu[src_reg];
         end
         else
            mem[{4'h0, copy_idx_reg[3:0]}] <=
               mem[{src_reg, copy_idx_reg[3:0]}];
      end
      else if (prog_wr && is_seg)
      begin
         case (fld)
            `SPS_FLD_KIND:
               mem[{pidx, sidx}].kind <= sps_pkg::sps_kind_t'(reg_wdata[1:0]);
            `SPS_FLD_TARGET:
               mem[{pidx, sidx}].target <= reg_wdata;
            `SPS_FLD_TIME:
               mem[{pidx, sidx}].seg_time <= reg_wdata;
            `SPS_FLD_EVENTS:
               mem[{pidx, sidx}].events <= reg_wdata[7:0];
            default:
               pcyc[0] <= pcyc[0];
         endcase
      end
      else if (prog_wr)
      begin
         if (pword == `SPS_GEN_CYCLES && reg_wdata <= 16'(`SPS_MAX_CYCLES))
            pcyc[pidx] <= reg_wdata[13:0];
         if (pword == `SPS_GEN_DWELL_U && reg_wdata[1:0] != 2'h3)
            pdwu[pidx] <= reg_wdata[1:0];
         if (pword == `SPS_GEN_RAMP_U && reg_wdata[1:0] != 2'h3)
            prmu[pidx] <= reg_wdata[1:0];
      end
   end

   // Sum of the remaining segments; a call makes it unknowable
   assign sm = mem[{4'h0, scan_idx_reg[3:0]}];
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         scan_busy_reg <= 1'b0;
         scan_ok_reg   <= 1'b0;
         scan_idx_reg  <= 5'h0;
         scan_sum_reg  <= 32'h0;
         rest_sum_reg  <= 32'h0;
      end
      else if (state_reg == sps_pkg::ST_LOAD ||
               (prog_wr && pidx == 4'h0))
      begin
         scan_busy_reg <= 1'b1;
         scan_ok_reg   <= 1'b1;
         scan_idx_reg  <= seg_reg + 5'h1;
         scan_sum_reg  <= 32'h0;
      end
      else if (scan_busy_reg)
      begin
         if (scan_idx_reg[4] || sm.kind == sps_pkg::SK_END)
         begin
            scan_busy_reg <= 1'b0;
            rest_sum_reg  <= scan_sum_reg;
         end
         else if (sm.kind == sps_pkg::SK_CALL)
         begin
            scan_busy_reg <= 1'b0;
            scan_ok_reg   <= 1'b0;
         end
         else
         begin
            scan_sum_reg <= sat_add(scan_sum_reg, to_ms(sm.seg_time,
               (sm.kind == sps_pkg::SK_RAMP) ? prmu[0] : pdwu[0]));
            scan_idx_reg <= scan_idx_reg + 5'h1;
         end
      end
   end

   assign prog_left = sat_add(seg_left_reg, rest_sum_reg);
   assign seg_sc    = scaled(seg_left_reg, res_reg);
   assign prg_sc    = scaled(prog_left, res_reg);
   assign ptime_ok  = scan_ok_reg && !scan_busy_reg &&
                      (state_reg == sps_pkg::ST_RUN ||
                       state_reg == sps_pkg::ST_HOLD);

   // Read data selection
   always_comb
   begin
      rd_val = 16'h0;
      if (in_prog && is_seg)
      begin
         case (fld)
            `SPS_FLD_KIND:   rd_val = {14'h0, mem[{pidx, sidx}].kind};
            `SPS_FLD_TARGET: rd_val = mem[{pidx, sidx}].target;
            `SPS_FLD_TIME:   rd_val = mem[{pidx, sidx}].seg_time;
            `SPS_FLD_EVENTS: rd_val = {8'h0, mem[{pidx, sidx}].events};
            default:         rd_val = 16'h0;
         endcase
      end
      else if (in_prog)
      begin
         case (pword)
            `SPS_GEN_CYCLES:  rd_val = {2'h0, pcyc[pidx]};
            `SPS_GEN_DWELL_U: rd_val = {14'h0, pdwu[pidx]};
            `SPS_GEN_RAMP_U:  rd_val = {14'h0, prmu[pidx]};
            default:          rd_val = 16'h0;
         endcase
      end
      else if (in_ctl)
      begin
         case (coff[3:0])
            `SPS_CTL_CMD:     rd_val = {11'h0, ptime_ok, 1'b0, state_reg};
            `SPS_CTL_SEL:     rd_val = {12'h0, sel_prog_reg};
            `SPS_CTL_ACCESS:  rd_val = {14'h0, access_reg};
            `SPS_CTL_RES:     rd_val = {14'h0, res_reg};
            `SPS_CTL_DIN_EN:  rd_val = {10'h0, din_en_reg};
            `SPS_CTL_CONFIG:  rd_val = {15'h0, cfg_mode};
            `SPS_CTL_SEGT_HI: rd_val = seg_sc[31:16];
            `SPS_CTL_SEGT_LO: rd_val = seg_sc[15:0];
            `SPS_CTL_PRGT_HI: rd_val = ptime_ok ? prg_sc[31:16] : 16'h0;
            `SPS_CTL_PRGT_LO: rd_val = ptime_ok ? prg_sc[15:0] : 16'h0;
            `SPS_CTL_SETPT:   rd_val = sp_reg;
            `SPS_CTL_RL_TGT:  rd_val = cur_seg_reg.target;
            `SPS_CTL_RL_TIME: rd_val = cur_seg_reg.seg_time;
            `SPS_CTL_SEGNUM:  rd_val = {11'h0, seg_reg};
            default:          rd_val = 16'h0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || !reg_rd)
         reg_rdata <= 16'h0;
      else
         reg_rdata <= rd_val;
   end

   assign event_out               = ev_reg;
   assign program_setpoint_output = sp_reg;
   assign seq_state               = state_reg;

endmodule : sps_sequencer

// File: hw/sps_consts.svh
// Constants of the setpoint program sequencer
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

`define SPS_CLK_MHZ      10
`define SPS_MS_NS        1000000
`define SPS_MS_CYC       (`SPS_MS_NS * `SPS_CLK_MHZ / 1000)
`define SPS_SEC_MS       32'd1000
`define SPS_MIN_MS       32'd60000
`define SPS_HOUR_MS      32'd3600000
`define SPS_TIME_CAP     32'd1800000000
`define SPS_MAX_CYCLES   14'd9999
`define SPS_LAST_PROG    4'd10
`define SPS_NPROG        11
`define SPS_NSEG         16

`define SPS_PROG0_BASE   16'h2000
`define SPS_PROG_STRIDE  11'h088
`define SPS_PROG_SPAN    16'h05d8
`define SPS_GEN_CYCLES   8'h00
`define SPS_GEN_DWELL_U  8'h01
`define SPS_GEN_RAMP_U   8'h02
`define SPS_SEG_FIRST    8'h08
`define SPS_FLD_KIND     3'h0
`define SPS_FLD_TARGET   3'h1
`define SPS_FLD_TIME     3'h2
`define SPS_FLD_EVENTS   3'h3

`define SPS_CTL_BASE     16'h2948
`define SPS_CTL_SPAN     16'h000e
`define SPS_CTL_CMD      4'h0
`define SPS_CTL_SEL      4'h1
`define SPS_CTL_ACCESS   4'h2
`define SPS_CTL_RES      4'h3
`define SPS_CTL_DIN_EN   4'h4
`define SPS_CTL_CONFIG   4'h5
`define SPS_CTL_SEGT_HI  4'h6
`define SPS_CTL_SEGT_LO  4'h7
`define SPS_CTL_PRGT_HI  4'h8
`define SPS_CTL_PRGT_LO  4'h9
`define SPS_CTL_SETPT    4'ha
`define SPS_CTL_RL_TGT   4'hb
`define SPS_CTL_RL_TIME  4'hc
`define SPS_CTL_SEGNUM   4'hd

`define SPS_CMD_RUN      16'h0001
`define SPS_CMD_HOLD     16'h0002
`define SPS_CMD_RESET    16'h0003

`define SPS_SEL_RST      4'h1
`define SPS_ACCESS_RST   2'h2
`define SPS_RES_RST      2'h0
`define SPS_DIN_EN_RST   6'h27
`define SPS_CYC_RST      14'h0001
`define SPS_UNITS_RST    2'h0

`endif

// File: hw/sps_pkg.sv
// Types of the setpoint program sequencer
package sps_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_COPY, ST_LOAD, ST_RUN, ST_HOLD, ST_DONE
   } sps_state_t;

   typedef enum logic [1:0] {
      SK_END, SK_RAMP, SK_DWELL, SK_CALL
   } sps_kind_t;

   typedef struct packed {
      logic advance;
      logic run_or_clear_input;
      logic run_or_freeze_input;
      logic clear;
      logic hold;
      logic run;
   } sps_din_t;

   typedef struct packed {
      logic run;
      logic hold;
      logic clear;
   } sps_panel_t;

   typedef struct packed {
      sps_kind_t   kind;
      logic [15:0] target;
      logic [15:0] seg_time;
      logic [7:0]  events;
   } sps_seg_t;

endpackage : sps_pkg

// File: sim/sps_field.sv
// Field pin model: pins change just after a clock edge
`timescale 1ns/1ns
module sps_field (
   // Clock
   input wire logic              clk,
   // Requested and driven pin levels
   input wire sps_pkg::sps_din_t req,
   output sps_pkg::sps_din_t     din
);
   initial din = '0;
   always @(posedge clk)
      din <= req;
endmodule : sps_field

// File: sim/sps_seq_monitor.sv
// Checker of the sequencer port behaviour
`timescale 1ns/1ns
module sps_seq_monitor (
   // Clock and reset
   input wire logic                clk,
   input wire logic                sys_rst,
   // Watched ports
   input wire logic                reg_rd,
   input wire logic [15:0]         reg_rdata,
   input wire sps_pkg::sps_din_t   din,
   input wire logic                config_mode_in,
   input wire logic [7:0]          event_out,
   input wire sps_pkg::sps_state_t seq_state
);
   logic [7:0] copy_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge clk)
      copy_cnt <= (seq_state == sps_pkg::ST_COPY) ? copy_cnt + 8'h01 : 8'h00;
   sequence s_run_edge;
      !din.run ##1 din.run && seq_state == sps_pkg::ST_IDLE && !din.clear
         && !config_mode_in;
   endsequence
   property p_start;
      s_run_edge |-> ##[2:6] seq_state == sps_pkg::ST_COPY;
   endproperty
   property p_copy;
      seq_state == sps_pkg::ST_LOAD && $past(seq_state) == sps_pkg::ST_COPY
         |-> copy_cnt == 8'h11;
   endproperty
   property p_events;
      $changed(event_out) |-> $past(seq_state) == sps_pkg::ST_LOAD
         || seq_state == sps_pkg::ST_IDLE;
   endproperty
   property p_rdata;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   property p_config;
      config_mode_in [*5] |-> seq_state == sps_pkg::ST_IDLE;
   endproperty
   property p_clear;
      din.clear [*5] |-> seq_state == sps_pkg::ST_IDLE;
   endproperty
   property p_hold;
      din.hold [*5] |-> seq_state != sps_pkg::ST_RUN;
   endproperty
   property p_advance;
      $rose(din.advance) && seq_state == sps_pkg::ST_RUN
         |-> ##[1:6] seq_state == sps_pkg::ST_LOAD;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   a_copy: assert property (p_copy) else $error("copy length");
   a_events: assert property (p_events) else $error("events moved");
   a_rdata: assert property (p_rdata) else $error("stray rdata");
   a_config: assert property (p_config) else $error("config run");
   a_clear: assert property (p_clear) else $error("clear ignored");
   a_hold: assert property (p_hold) else $error("hold ignored");
   a_advance: assert property (p_advance) else $error("no advance");
endmodule : sps_seq_monitor
bind sps_sequencer sps_seq_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .din(din),
   .config_mode_in(config_mode_in), .event_out(event_out),
   .seq_state(seq_state));

// File: sim/tb_top.sv
// Self-checking bench of the setpoint program sequencer
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic config_mode_in = 1'b0;
   sps_pkg::sps_panel_t panel_cmd = '0;
   logic [1:0] panel_level = 2'h0;
   logic [15:0] reg_rdata;
   logic [15:0] program_setpoint_output;
   logic [7:0] event_out;
   sps_pkg::sps_din_t req = '0;
   sps_pkg::sps_din_t din;
   sps_pkg::sps_state_t seq_state;
   int bad_count = 0;
   int n_checks = 0;
   always #50 clk = ~clk;
   sps_field u_field (.clk(clk), .req(req), .din(din));
   sps_sequencer #(.MS_CYC(10)) u_dut (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .din(din),
      .config_mode_in(config_mode_in), .panel_cmd(panel_cmd),
      .panel_level(panel_level), .event_out(event_out),
      .program_setpoint_output(program_setpoint_output),
      .seq_state(seq_state));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rc(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rc
   task wst(input sps_pkg::sps_state_t s);
      #1;
      for (int i = 0; i < 300 && seq_state !== s; i++)
         @(posedge clk) #1;
      chk({13'h0000, seq_state}, {13'h0000, s});
   endtask : wst
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rc(16'h294a, 16'h0002);
      wr(16'h2949, 16'h000b);
      rc(16'h2949, 16'h0001);
      wr(16'h2949, 16'h0002);
      rc(16'h2949, 16'h0002);
      wr(16'h2001, 16'h0002);
      rc(16'h2001, 16'h0000);
      wr(16'h2118, 16'h0002);
      wr(16'h2119, 16'h0055);
      wr(16'h211a, 16'h0001);
      wr(16'h211b, 16'h00a5);
      wr(16'h2120, 16'h0000);
      wr(16'h2123, 16'h003c);
      $display("end of test: registers");
      @(posedge clk) req.run <= 1'b1;
      wst(sps_pkg::ST_RUN);
      chk({8'h00, event_out}, 16'h00a5);
      @(posedge clk) req.hold <= 1'b1;
      wst(sps_pkg::ST_HOLD);
      wr(16'h2001, 16'h0001);
      rc(16'h2001, 16'h0001);
      rc(16'h200b, 16'h00a5);
      rc(16'h211b, 16'h00a5);
      rc(16'h2111, 16'h0000);
      @(posedge clk) req.hold <= 1'b0;
      wst(sps_pkg::ST_RUN);
      @(posedge clk) req.advance <= 1'b1;
      wst(sps_pkg::ST_DONE);
      chk({8'h00, event_out}, 16'h003c);
      chk(program_setpoint_output, 16'h0055);
      $display("end of test: program run");
      @(posedge clk) req <= 6'h04;
      wst(sps_pkg::ST_IDLE);
      chk({8'h00, event_out}, 16'h0000);
      @(posedge clk) config_mode_in <= 1'b1;
      @(posedge clk) req <= 6'h01;
      repeat (30) @(posedge clk);
      #1 chk({13'h0000, seq_state}, 16'h0000);
      $display("end of test: reset levels");
      @(posedge clk) config_mode_in <= 1'b0;
      req <= 6'h00;
      panel_level <= 2'h1;
      repeat (5) @(posedge clk);
      panel_cmd.run <= 1'b1;
      @(posedge clk) panel_cmd.run <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk({13'h0000, seq_state}, 16'h0000);
      @(posedge clk) panel_level <= 2'h2;
      panel_cmd.run <= 1'b1;
      @(posedge clk) panel_cmd.run <= 1'b0;
      wst(sps_pkg::ST_RUN);
      wr(16'h2948, 16'h0002);
      wst(sps_pkg::ST_HOLD);
      rc(16'h2948, 16'h0014);
      @(posedge clk) panel_cmd.clear <= 1'b1;
      @(posedge clk) panel_cmd.clear <= 1'b0;
      wst(sps_pkg::ST_IDLE);
      $display("end of test: panel and commands");
      wrap_up();
   end
   initial
   begin
      #500000;
      bad_count++;
      wrap_up();
   end
endmodule : tb_top
